// *** common/ild_consts.svh ***
`ifndef ILD_CONSTS_SVH
`define ILD_CONSTS_SVH

`define ILD_ADDR_CTRL       12'h000
`define ILD_ADDR_PRELOAD    12'h004
`define ILD_ADDR_START      12'h008
`define ILD_ADDR_RESET      12'h00C
`define ILD_ADDR_THRESH     12'h010
`define ILD_ADDR_STATUS     12'h014
`define ILD_ADDR_LVL0       12'h018
`define ILD_ADDR_LVL1       12'h01C
`define ILD_ADDR_LVL2       12'h020

`define ILD_CTRL_TWOS       0
`define ILD_CTRL_INTERP     1
`define ILD_CTRL_ONESHOT    2
`define ILD_PRE_LO          14
`define ILD_PRE_HI          29
`define ILD_PRE_SYNC_EN     17
`define ILD_PRE_LSB_ONES    23
`define ILD_STAT_READY      0
`define ILD_STAT_RUN        1

`define ILD_SAMPLE_W        14
`define ILD_ACC_W           32
`define ILD_CNT_W           18
`define ILD_RST_PERIOD_NS   100
`define ILD_CLK_PERIOD_NS   10
`define ILD_RST_CYCLES      (`ILD_RST_PERIOD_NS / `ILD_CLK_PERIOD_NS)

`endif

// *** common/ild_pkg.sv ***
package ild_pkg;
    typedef enum logic [1:0] {
        ILD_IDLE = 2'b01,
        ILD_RUN  = 2'b10
    } ild_state_e;
    typedef logic [11:0] ild_addr_t;
endpackage

// *** rtl/ild_input_stage.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ild_consts.svh"
module ild_input_stage #(
    parameter int W = `ILD_SAMPLE_W
) (
    input  wire logic         pclk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] sample_in,
    input  wire logic         sample_en,
    input  wire logic         twos_fmt,
    input  wire logic         interp,
    output logic [W-1:0]      sample_out,
    output logic              sample_valid
);
    always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            sample_out   <= '0;
            sample_valid <= 1'b0;
        end else if (interp) begin
            sample_valid <= 1'b1;
            sample_out   <= sample_en ? (twos_fmt ? sample_in
                            : {~sample_in[W-1], sample_in[W-2:0]}) : '0;
        end else begin
            sample_valid <= sample_en;
            if (sample_en) begin
                sample_out <= twos_fmt ? sample_in
                            : {~sample_in[W-1], sample_in[W-2:0]};
            end
        end
    end
endmodule // ild_input_stage
`default_nettype wire

// *** rtl/ild_level_detector.sv ***
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ild_consts.svh"
module ild_level_detector #(
    parameter int SW = `ILD_SAMPLE_W
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire ild_pkg::ild_addr_t    paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [SW-1:0]         adc_sample,
    input  wire logic                  input_sample_enable,
    input  wire logic                  front_sync_input,
    output logic [SW-1:0]              filter_sample,
    output logic                       filter_valid,
    output logic                       result_ready
);
    import ild_pkg::*;

    logic [31:0]           ctrl;
    logic [31:0]           preload_cfg;
    logic [31:0]           thresh;
    logic [SW-1:0]         adc_s1, adc_s2;
    logic                  en_s1, en_s2;
    logic                  sync_s1, sync_s2, sync_s3;
    logic [3:0]            rst_cnt;
    logic                  fe_rst_n;
    logic                  fe_rst_q;
    logic [SW-1:0]         smp;
    logic                  smp_valid;
    logic [`ILD_ACC_W-1:0] acc;
    logic [`ILD_CNT_W-1:0] cnt;
    logic [22:0]           held;
    ild_state_e            state;
    logic                  start_wr;
    logic                  sync_start;
    logic                  restart;
    logic                  terminal;
    logic                  bus_wr;
    logic                  bus_rd;
    logic                  mapped;
    logic [`ILD_CNT_W-1:0] preload_val;
    logic [`ILD_ACC_W-1:0] term;
    logic [31:0]           next_rdata;
    logic [31:0]           status_word;
    logic                  overrun;
    logic                  setup;
    logic                  wr_ctrl;
    logic                  wr_pre;
    logic                  wr_thr;
    logic                  wr_reset;
    logic                  rd_status;
    logic                  rd_lvl2;
    logic                  sync_rise;
    logic                  accept;

    function automatic logic [SW-1:0] sample_mag(input logic [SW-1:0] s);
        // The most negative code maps to its unsigned magnitude
        return s[SW-1] ? (~s + 1'b1) : s;
    endfunction

    function automatic logic [`ILD_ACC_W-1:0] mag_plus_thr(input logic [SW-1:0] s,
                                                        input logic [31:0] t);
        return `ILD_ACC_W'({{(`ILD_ACC_W-SW){1'b0}}, sample_mag(s)} + t);
    endfunction

    function automatic logic reg_hit(input ild_addr_t a, input ild_addr_t off);
        return a == off;
    endfunction

    function automatic logic addr_mapped(input ild_addr_t a);
        logic ok;
        ok = 1'b0;
        unique case (a)
            `ILD_ADDR_CTRL:    ok = 1'b1;
            `ILD_ADDR_PRELOAD: ok = 1'b1;
            `ILD_ADDR_START:   ok = 1'b1;
            `ILD_ADDR_RESET:   ok = 1'b1;
            `ILD_ADDR_THRESH:  ok = 1'b1;
            `ILD_ADDR_STATUS:  ok = 1'b1;
            `ILD_ADDR_LVL0:    ok = 1'b1;
            `ILD_ADDR_LVL1:    ok = 1'b1;
            `ILD_ADDR_LVL2:    ok = 1'b1;
            default:           ok = 1'b0;
        endcase
        return ok;
    endfunction

    assign bus_wr = psel && penable && pwrite;
    assign bus_rd = psel && penable && !pwrite;
    assign mapped    = addr_mapped(paddr);
    assign setup     = psel && !penable;
    assign wr_ctrl   = bus_wr && reg_hit(paddr, `ILD_ADDR_CTRL);
    assign wr_pre    = bus_wr && reg_hit(paddr, `ILD_ADDR_PRELOAD);
    assign wr_thr    = bus_wr && reg_hit(paddr, `ILD_ADDR_THRESH);
    assign wr_reset  = bus_wr && reg_hit(paddr, `ILD_ADDR_RESET);
    assign rd_status = bus_rd && reg_hit(paddr, `ILD_ADDR_STATUS);
    assign rd_lvl2   = bus_rd && reg_hit(paddr, `ILD_ADDR_LVL2);

    // Pin inputs double synchronised
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_s1 <= '0;
            adc_s2 <= '0;
        end else begin
            adc_s1 <= adc_sample;
            adc_s2 <= adc_s1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_s1 <= 1'b0;
            en_s2 <= 1'b0;
        end else begin
            en_s1 <= input_sample_enable;
            en_s2 <= en_s1;
        end
    end

    // Third stage only remembers the last level for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_s1 <= 1'b0;
            sync_s2 <= 1'b0;
            sync_s3 <= 1'b0;
        end else begin
            sync_s1 <= front_sync_input;
            sync_s2 <= sync_s1;
            sync_s3 <= sync_s2;
        end
    end

    // Stretched software reset of the front end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cnt <= '0;
        end else if (wr_reset) begin
            rst_cnt <= 4'(`ILD_RST_CYCLES);
        end else if (rst_cnt != '0) begin
            rst_cnt <= rst_cnt - 4'h1;
        end
    end

    // The front end leaves reset one edge after the count runs out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fe_rst_q <= 1'b0;
        end else begin
            fe_rst_q <= (rst_cnt == '0);
        end
    end
    assign fe_rst_n = presetn && fe_rst_q;

    // Format conversion and gating or zero stuffing
    ild_input_stage #(.W(SW)) u_in (
        .pclk         (pclk),
        .rst_n        (fe_rst_n),
        .sample_in    (adc_s2),
        .sample_en    (en_s2),
        .twos_fmt     (ctrl[`ILD_CTRL_TWOS]),
        .interp       (ctrl[`ILD_CTRL_INTERP]),
        .sample_out   (smp),
        .sample_valid (smp_valid)
    );

    // Output stage toward the filters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filter_sample <= '0;
        end else begin
            filter_sample <= smp;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filter_valid <= 1'b0;
        end else begin
            filter_valid <= smp_valid;
        end
    end

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= '0;
        end else if (wr_ctrl) begin
            ctrl <= {29'h0, pwdata[2:0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            preload_cfg <= '0;
        end else if (wr_pre) begin
            preload_cfg <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thresh <= '0;
        end else if (wr_thr) begin
            thresh <= pwdata;
        end
    end

    assign preload_val = {preload_cfg[`ILD_PRE_HI:`ILD_PRE_LO],
                          {2{preload_cfg[`ILD_PRE_LSB_ONES]}}};
    assign start_wr    = bus_wr && reg_hit(paddr, `ILD_ADDR_START);
    assign sync_rise   = sync_s2 && !sync_s3;
    assign sync_start  = preload_cfg[`ILD_PRE_SYNC_EN] && sync_rise;
    assign restart     = start_wr || sync_start;
    assign accept      = (state == ILD_RUN) && smp_valid;
    assign term        = mag_plus_thr(smp, thresh);
    // A restart in the same cycle wins, so nothing is latched then
    assign terminal    = accept && !restart && (cnt == `ILD_CNT_W'(1));

    // Integration state: running or halted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ILD_IDLE;
        end else begin
            unique case (state)
                ILD_IDLE: begin
                    if (restart) begin
                        state <= ILD_RUN;
                    end
                end
                ILD_RUN: begin
                    if (terminal && ctrl[`ILD_CTRL_ONESHOT]) begin
                        state <= ILD_IDLE;
                    end
                end
            endcase
        end
    end

    // Integration period down-counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
        end else if (restart) begin
            cnt <= preload_val;
        end else if (terminal) begin
            cnt <= ctrl[`ILD_CTRL_ONESHOT] ? '0 : preload_val;
        end else if (accept) begin
            cnt <= cnt - `ILD_CNT_W'(1);
        end
    end

    // Accumulator; the terminal sample itself is not summed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= '0;
        end else if (restart || terminal) begin
            acc <= '0;
        end else if (accept) begin
            acc <= acc + term;
        end
    end

    // Result holding register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held <= '0;
        end else if (terminal) begin
            held <= acc[`ILD_ACC_W-1 -: 23];
        end
    end

    // Ready flag: a latch in the same cycle as the clearing read wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_ready <= 1'b0;
        end else if (terminal) begin
            result_ready <= 1'b1;
        end else if (rd_lvl2) begin
            result_ready <= 1'b0;
        end
    end

    // A result latched while the previous one is unread is an overrun
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overrun <= 1'b0;
        end else if (terminal && result_ready) begin
            overrun <= 1'b1;
        end else if (rd_status) begin
            overrun <= 1'b0;
        end
    end

    assign status_word = {29'h0, overrun, state == ILD_RUN, result_ready};

    always_comb begin
        next_rdata = '0;
        unique case (paddr)
            `ILD_ADDR_CTRL:    next_rdata = ctrl;
            `ILD_ADDR_PRELOAD: next_rdata = preload_cfg;
            `ILD_ADDR_THRESH:  next_rdata = thresh;
            `ILD_ADDR_STATUS:  next_rdata = status_word;
            `ILD_ADDR_LVL0:    next_rdata = {24'h0, held[7:0]};
            `ILD_ADDR_LVL1:    next_rdata = {24'h0, held[15:8]};
            `ILD_ADDR_LVL2:    next_rdata = {25'h0, held[22:16]};
            default:           next_rdata = '0;
        endcase
    end

    // APB slave: no wait states, read data and error registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup) begin
            prdata <= next_rdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup && !mapped;
        end
    end
endmodule // ild_level_detector
`default_nettype wire

// *** test/ild_adc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ild_adc_model (
    input  wire logic        pclk,
    input  wire logic        run,
    input  wire logic [13:0] value,
    output logic [13:0]      adc_sample,
    output logic             input_sample_enable
);
    // Half-rate converter; between samples the bus shows the inverse
    always @(posedge pclk) begin
        input_sample_enable <= run && !input_sample_enable;
        adc_sample <= (run && !input_sample_enable) ? value : ~value;
    end
endmodule // ild_adc_model
`default_nettype wire

// *** test/ild_level_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ild_consts.svh"
module ild_level_checker (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire ild_pkg::ild_addr_t paddr,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic               result_ready
);
    import ild_pkg::*;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_ready_after_setup: assert property ((psel && !penable) |=> pready)
        else $error("no ready after setup");
    chk_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    chk_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready too long");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_unmapped_err: assert property ((pready && (paddr > `ILD_ADDR_LVL2
        || paddr[1:0] != 2'h0)) |-> pslverr)
        else $error("unmapped without error");
    chk_err_no_data: assert property ((pslverr && !pwrite) |-> prdata == 32'h0)
        else $error("error read not zero");
    chk_level_top_zero: assert property ((pready && !pwrite && paddr == `ILD_ADDR_LVL2)
        |-> prdata[31:7] == 25'h0)
        else $error("level top bits set");
    chk_ready_clear: assert property ((pready && !pwrite && paddr == `ILD_ADDR_LVL2)
        |=> !result_ready)
        else $error("ready not cleared");
endmodule // ild_level_checker
bind ild_level_detector ild_level_checker u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .result_ready(result_ready));
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ild_consts.svh"
module testbench;
    import ild_pkg::*;
    typedef struct {
        logic [2:0]  ctrl;
        logic [31:0] pre;
        logic [31:0] thr;
        logic [13:0] smp;
        logic        sy;
        logic        rs;
        logic [22:0] ex;
    } ild_row_s;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, fsync = 1'b0, run = 1'b0;
    ild_addr_t   paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd, lvl;
    logic [13:0] val = 14'h0, adc_sample, filter_sample;
    logic        pready, pslverr, er, ise, filter_valid, result_ready;
    int          errors = 0, n_tests = 0, k, cnt;
    ild_row_s    rows[8] = '{
        '{3'h5, 32'hC000, 32'h0, 14'h1000, 1'h0, 1'h0, 23'h58},
        '{3'h4, 32'hC000, 32'h0, 14'h3000, 1'h0, 1'h0, 23'h58},
        '{3'h5, 32'hC000, 32'h0, 14'h3000, 1'h0, 1'h0, 23'h58},
        '{3'h5, 32'hC000, 32'hFFFFF800, 14'h1000, 1'h0, 1'h0, 23'h2C},
        '{3'h5, 32'h80C000, 32'h0, 14'h1000, 1'h0, 1'h0, 23'h4070},
        '{3'h5, 32'h2C000, 32'h0, 14'h1000, 1'h1, 1'h0, 23'h158},
        '{3'h5, 32'hC000, 32'h0, 14'h1000, 1'h0, 1'h1, 23'h58},
        '{3'h1, 32'hC000, 32'h0, 14'h1000, 1'h0, 1'h0, 23'h58}};
    always #5 pclk = ~pclk;
    ild_adc_model u_ild_adc_model (.pclk(pclk), .run(run), .value(val),
        .adc_sample(adc_sample), .input_sample_enable(ise));
    ild_level_detector u_ild_level_detector (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .adc_sample(adc_sample),
        .input_sample_enable(ise), .front_sync_input(fsync),
        .filter_sample(filter_sample), .filter_valid(filter_valid),
        .result_ready(result_ready));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        if (errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input ild_addr_t a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_ready(input int lim);
        k = 0;
        while (result_ready !== 1'b1 && k < lim) begin
            @(negedge pclk);
            k++;
        end
    endtask
    task automatic count_valid(input int n);
        cnt = 0;
        repeat (n) begin
            @(negedge pclk);
            cnt += (filter_valid === 1'b1);
        end
    endtask
    task automatic sync_pulse;
        @(posedge pclk);
        fsync <= 1'b1;
        @(posedge pclk);
        fsync <= 1'b0;
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            run <= 1'b0;
            repeat (8) @(posedge pclk);
            apb(1'b1, `ILD_ADDR_CTRL, {29'h0, rows[i].ctrl});
            apb(1'b1, `ILD_ADDR_THRESH, rows[i].thr);
            apb(1'b1, `ILD_ADDR_PRELOAD, rows[i].pre);
            val <= rows[i].smp;
            if (rows[i].sy) sync_pulse();
            else apb(1'b1, `ILD_ADDR_START, 32'h0);
            run <= 1'b1;
            if (rows[i].rs) begin
                repeat (16) @(posedge pclk);
                apb(1'b1, `ILD_ADDR_START, 32'h0);
                chk(result_ready, 32'h0);
            end
            wait_ready(5000);
            apb(1'b0, `ILD_ADDR_STATUS, 32'h0);
            chk(rd[0], 32'h1);
            for (int j = 0; j < 3; j++) begin
                apb(1'b0, ild_addr_t'(`ILD_ADDR_LVL0 + 4 * j), 32'h0);
                lvl[8*j+:8] = rd[7:0];
            end
            chk(lvl, {9'h0, rows[i].ex});
            @(negedge pclk);
            chk(result_ready, 32'h0);
            wait_ready(60);
            chk(result_ready, {31'h0, !rows[i].ctrl[2]});
        end
        apb(1'b0, 12'h024, 32'h0);
        chk(er, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, `ILD_ADDR_CTRL, 32'h1);
        count_valid(10);
        count_valid(40);
        chk(cnt, 32'd20);
        while (filter_valid !== 1'b1) @(negedge pclk);
        chk(filter_sample, 32'h1000);
        apb(1'b1, `ILD_ADDR_CTRL, 32'h3);
        count_valid(10);
        count_valid(40);
        chk(cnt, 32'd40);
        @(negedge pclk);
        lvl = filter_sample;
        @(negedge pclk);
        chk(lvl ^ filter_sample, 32'h1000);
        apb(1'b1, `ILD_ADDR_RESET, 32'h0);
        repeat (2) @(negedge pclk);
        count_valid(9);
        chk(cnt, 32'd0);
        count_valid(4);
        count_valid(8);
        chk(cnt, 32'd8);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `ILD_ADDR_STATUS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `ILD_ADDR_LVL0, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, `ILD_ADDR_CTRL, 32'h5);
        apb(1'b1, `ILD_ADDR_PRELOAD, 32'hC000);
        sync_pulse();
        wait_ready(150);
        chk(result_ready, 32'h0);
        end_of_test();
    end
    initial begin
        #300us;
        errors++;
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
